// file: icp_bus_master.sv
// Behavioural two-wire bus master driving the control port's pins.
// Assumes the tb resolves the open-drain data line and feeds sda_line.
`timescale 1ns/100ps
`default_nettype none
module icp_bus_master #(
   parameter int Q = 8
) (
   input  wire logic clock,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   // ==========================================================
   // Idle bus: both lines released high
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Quarter bit period, edges placed off the sampling edge
   task automatic tick();
      repeat (Q) @(negedge clock);
   endtask : tick

   // Start or repeated start, never a stop between phases
   task automatic start();
      sda_drv = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b0;
      tick();
      scl = 1'b0;
      tick();
   endtask : start

   // Stop ends every transfer
   task automatic stop();
      sda_drv = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b1;
      tick();
   endtask : stop

   // One bit out, line sampled while clock high
   task automatic bit_io(input logic b, output logic s);
      sda_drv = b;
      tick();
      scl = 1'b1;
      tick();
      s = sda_line;
      tick();
      scl = 1'b0;
      tick();
   endtask : bit_io

   // Byte out MSB first, then ninth bit released for ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : wbyte

   // Byte in, ack unless last, which is answered with nack
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask : rbyte
endmodule : icp_bus_master
`default_nettype wire

// file: icp_pkg.sv
// Constants and types of the paged two-wire control port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package icp_pkg;

   // ==========================================================
   // Slave address and register index
   localparam logic [4:0] ADDR_FIXED   = 5'h13;   // Fixed upper address bits 10011
   localparam logic [6:0] IDX_RST      = 7'h00;
   localparam logic [6:0] IDX_LAST     = 7'h7F;
   localparam logic [6:0] IDX_WRAP     = 7'h00;

   // ==========================================================
   // Page and book selection
   localparam logic [6:0] REG_PAGE     = 7'h00;
   localparam logic [6:0] REG_BOOK     = 7'h7F;
   localparam logic [7:0] PAGE_ZERO    = 8'h00;
   localparam logic [7:0] PAGE_RST     = 8'h00;
   localparam logic [7:0] BOOK_RST     = 8'h00;

   // ==========================================================
   // Coefficient book, swap register and host buffer window
   localparam logic [7:0]  COEF_BOOK      = 8'h8C;
   localparam logic [7:0]  SWAP_PAGE      = 8'h01;
   localparam logic [6:0]  SWAP_REG       = 7'h10;
   localparam logic [6:0]  SWAP_REG_LAST  = 7'h13;
   localparam logic [31:0] SWAP_VALUE     = 32'h00000001;
   localparam logic [31:0] SWAP_RST       = 32'h00000000;
   localparam logic [7:0]  COEF_PAGE_LO   = 8'h1B;
   localparam logic [6:0]  COEF_REG_LO    = 7'h58;
   localparam logic [7:0]  COEF_PAGE_HI   = 8'h22;
   localparam logic [6:0]  COEF_REG_HI    = 7'h1C;
   localparam logic [14:0] COEF_LIN_LO    = {COEF_PAGE_LO, COEF_REG_LO};
   localparam logic [14:0] COEF_LIN_HI    = {COEF_PAGE_HI, COEF_REG_HI};
   localparam int          COEF_BYTES     = int'(COEF_LIN_HI) - int'(COEF_LIN_LO) + 1;

   // ==========================================================
   // Types
   typedef logic [COEF_BYTES-1:0][7:0] icp_coef_t;

   // Pin levels after synchronisation
   typedef struct packed {
      logic scl;
      logic sda;
      logic adr_hi;
      logic adr_lo;
   } icp_pins_t;

   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} icp_state_t;

endpackage : icp_pkg
`default_nettype wire

// file: icp_port.sv
// Paged two-wire slave control port with coefficient swap.
// Assumes scl/sda/address pins are asynchronous; the audio sample
// clock is a second, unrelated domain.
// Behaviour
// [R1] Device is only slave receiver or transmitter
// [R2] Master writes: address, register, data, stop
// [R3] Each written byte stored, index advances (only page, book, swap and host buffer bytes are kept)
// [R4] Index wraps from 0x7F to zero
// [R5] Auto-increment never leaves current page
// [R6] Master loads index by write before reading
// [R7] Repeated start separates index write from read
// [R8] Each sent byte advances index by one
// [R9] Master NACKs last byte; device releases data
// [R10] Register zero of every page selects page
// [R11] Register 0x7F on page zero selects book
// [R12] Master reaches page zero before book change
// [R13] Swap copies all coefficients within one sample
// [R14] Swap flag high until buffer fully copied
// [R15] Master avoids buffer writes while flag high
// [R16] Coefficient writes act only after a swap
// [R17] Writing 0x00000001 to swap register starts transfer
// [R18] Configuration only through the two-wire port
// [R19] Address is 10011 plus two select pins
// [R20] Works at standard and fast bus rates
// [R21] Acknowledge own address and written bytes
// [R22] Reset clears index, page and book
`timescale 1ns/100ps
`default_nettype none
module icp_port (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               audio_clk,
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output var  logic               sda_o_q,
   output var  logic               sda_oe_q,
   input  wire logic               address_select_high,
   input  wire logic               address_select_low,
   output var  logic [7:0]         page_q,
   output var  logic [7:0]         book_q,
   output var  logic               swap_busy_q,
   output var  icp_pkg::icp_coef_t proc_mem_q
);
   import icp_pkg::*;

   // ==========================================================
   // Helpers
   // Linear offset of a page/index pair inside the host buffer
   function automatic logic [15:0] coef_off(input logic [7:0] pg, input logic [6:0] ix);
      logic [14:0] lin;
      lin      = {pg, ix};
      coef_off = {1'b0, lin - COEF_LIN_LO};
   endfunction : coef_off

   // True when the access falls in the host buffer window
   function automatic logic in_coef(input logic [7:0] bk, input logic [7:0] pg, input logic [6:0] ix);
      in_coef = (bk == COEF_BOOK) && ({pg, ix} >= COEF_LIN_LO) && ({pg, ix} <= COEF_LIN_HI);
   endfunction : in_coef

   // Index advance confined to the page, wrapping at the top
   function automatic logic [6:0] next_idx(input logic [6:0] ix);
      next_idx = (ix == IDX_LAST) ? IDX_WRAP : ix + 7'h01;   // [R4] [R5]
   endfunction : next_idx

   // ==========================================================
   // Pin synchronisation and bus events
   icp_pins_t  pins_raw;
   icp_pins_t  pins_s;
   icp_pins_t  prev_q;
   icp_pins_t  prev_d;
   logic       scl_rise, scl_fall;
   logic       start_ev, stop_ev;
   logic       done_tgl, done_s;

   assign pins_raw = '{scl: scl_i, sda: sda_i, adr_hi: address_select_high, adr_lo: address_select_low};

   icp_sync #(.W(4)) u_pin_sync (
      .clock (clock),
      .rst   (rst),
      .d     (pins_raw),
      .q     (pins_s)
   );

   icp_sync #(.W(1)) u_done_sync (
      .clock (clock),
      .rst   (rst),
      .d     (done_tgl),
      .q     (done_s)
   );

   // Edge and condition decode; 125 MHz oversamples fast mode widely [R20]
   always_comb begin
      prev_d   = pins_s;
      scl_rise = pins_s.scl & ~prev_q.scl;
      scl_fall = ~pins_s.scl & prev_q.scl;
      start_ev = pins_s.scl & prev_q.scl & prev_q.sda & ~pins_s.sda;
      stop_ev  = pins_s.scl & prev_q.scl & ~prev_q.sda & pins_s.sda;
   end

   // ==========================================================
   // Framing state and register file
   icp_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic       rw_q, rw_d;
   logic       first_q, first_d;
   logic [6:0] idx_q, idx_d;
   logic [7:0] page_d, book_d;
   logic       sda_oe_d;
   logic [31:0] swap_sh_q, swap_sh_d;
   logic       req_tgl_q, req_tgl_d;
   logic       seen_done_q, seen_done_d;
   logic       swap_busy_d;
   icp_coef_t  host_q, host_d;
   logic       addr_hit, wr_ev, swap_go;
   logic [7:0] rd_byte;
   logic [15:0] off_w, off_r;

   // Read data for the current index
   always_comb begin
      off_r   = coef_off(page_q, idx_q);
      rd_byte = 8'h00;
      if (idx_q == REG_PAGE) begin
         rd_byte = page_q;
      end else if (page_q == PAGE_ZERO && idx_q == REG_BOOK) begin
         rd_byte = book_q;
      end else if (book_q == COEF_BOOK && page_q == SWAP_PAGE && idx_q >= SWAP_REG && idx_q <= SWAP_REG_LAST) begin
         rd_byte = (idx_q == SWAP_REG_LAST) ? {7'h00, swap_busy_q} : 8'h00;   // [R14]
      end else if (in_coef(book_q, page_q, idx_q)) begin
         rd_byte = host_q[off_r[9:0]];
      end
   end

   // Next state of framing, index, selection and buffers
   always_comb begin
      state_d     = state_q;
      cnt_d       = cnt_q;
      shift_d     = shift_q;
      rw_d        = rw_q;
      first_d     = first_q;
      idx_d       = idx_q;
      page_d      = page_q;
      book_d      = book_q;
      sda_oe_d    = sda_oe_q;
      swap_sh_d   = swap_sh_q;
      req_tgl_d   = req_tgl_q;
      host_d      = host_q;
      addr_hit    = (shift_q[7:1] == {ADDR_FIXED, pins_s.adr_hi, pins_s.adr_lo});   // [R19]
      wr_ev       = 1'b0;
      swap_go     = 1'b0;
      off_w       = coef_off(page_q, idx_q);
      seen_done_d = done_s;
      if (start_ev) begin
         // Start or repeated start: the master owns framing [R1] [R7]
         state_d  = ST_ADDR;
         cnt_d    = 4'h0;
         sda_oe_d = 1'b0;
      end else if (stop_ev) begin
         state_d  = ST_IDLE;
         sda_oe_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               sda_oe_d = 1'b0;   // [R1]
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], pins_s.sda};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  if (addr_hit) begin
                     sda_oe_d = 1'b1;   // [R21]
                     state_d  = ST_ACK;
                     rw_d     = shift_q[0];
                     first_d  = ~shift_q[0];
                  end else begin
                     state_d = ST_IDLE;   // [R21]
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     // Present the indexed byte, then advance [R8]
                     shift_d  = {rd_byte[6:0], 1'b0};
                     sda_oe_d = ~rd_byte[7];
                     idx_d    = next_idx(idx_q);
                     state_d  = ST_TX;
                  end else begin
                     sda_oe_d = 1'b0;
                     state_d  = ST_RX;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], pins_s.sda};
                  cnt_d   = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  sda_oe_d = 1'b1;   // [R21]
                  state_d  = ST_ACK;
                  if (first_q) begin
                     // Register address byte; top bit ignored, low seven bits load the index [R6]
                     idx_d   = shift_q[6:0];
                     first_d = 1'b0;
                  end else begin
                     wr_ev = 1'b1;   // [R18]
                     idx_d = next_idx(idx_q);   // [R3]
                     if (idx_q == REG_PAGE) begin
                        page_d = shift_q;   // [R10]
                     end else if (page_q == PAGE_ZERO && idx_q == REG_BOOK) begin
                        book_d = shift_q;   // [R11] [R12]
                     end else if (book_q == COEF_BOOK && page_q == SWAP_PAGE &&
                                  idx_q >= SWAP_REG && idx_q <= SWAP_REG_LAST) begin
                        swap_sh_d = {swap_sh_q[23:0], shift_q};
                        if (idx_q == SWAP_REG_LAST && {swap_sh_q[23:0], shift_q} == SWAP_VALUE &&
                            !swap_busy_q) begin
                           swap_go   = 1'b1;
                           req_tgl_d = ~req_tgl_q;   // [R17]
                        end
                     end else if (in_coef(book_q, page_q, idx_q)) begin
                        host_d[off_w[9:0]] = shift_q;   // [R16]
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     sda_oe_d = 1'b0;
                     state_d  = ST_MACK;
                  end else begin
                     sda_oe_d = ~shift_q[7];
                     shift_d  = {shift_q[6:0], 1'b0};
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  // Master NACK ends the read; data line stays released [R9]
                  state_d = pins_s.sda ? ST_IDLE : ST_ACK;
               end
            end
         endcase
      end
      // Flag set by request, cleared only when copy reports back
      swap_busy_d = swap_go | (swap_busy_q & ~(done_s ^ seen_done_q));   // [R14]
   end

   // Registers; reset clears index, page, book [R22]
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_q      <= '0;
         state_q     <= ST_IDLE;
         cnt_q       <= 4'h0;
         shift_q     <= 8'h00;
         rw_q        <= 1'b0;
         first_q     <= 1'b0;
         idx_q       <= IDX_RST;
         page_q      <= PAGE_RST;
         book_q      <= BOOK_RST;
         sda_oe_q    <= 1'b0;
         sda_o_q     <= 1'b0;
         swap_sh_q   <= SWAP_RST;
         req_tgl_q   <= 1'b0;
         seen_done_q <= 1'b0;
         swap_busy_q <= 1'b0;
         host_q      <= '0;
      end else begin
         prev_q      <= prev_d;
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         shift_q     <= shift_d;
         rw_q        <= rw_d;
         first_q     <= first_d;
         idx_q       <= idx_d;
         page_q      <= page_d;
         book_q      <= book_d;
         sda_oe_q    <= sda_oe_d;
         sda_o_q     <= 1'b0;   // Open drain: only ever pulls low
         swap_sh_q   <= swap_sh_d;
         req_tgl_q   <= req_tgl_d;
         seen_done_q <= seen_done_d;
         swap_busy_q <= swap_busy_d;
         host_q      <= host_d;
      end
   end

   // ==========================================================
   // Swap engine in the audio sample domain
   icp_swap u_swap (
      .audio_clk  (audio_clk),
      .rst        (rst),
      .req_tgl    (req_tgl_q),
      .host_mem   (host_q),
      .done_tgl_q (done_tgl),
      .proc_mem_q (proc_mem_q)
   );

   // ==========================================================
   // Checks
   property p_idle_quiet;
      @(posedge clock) disable iff (rst) (state_q == ST_IDLE) |-> !sda_oe_q;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("data driven while idle"); // [R1]
   property p_addr_ack;
      @(posedge clock) disable iff (rst)
      (state_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && addr_hit && !start_ev && !stop_ev)
         |=> sda_oe_q && state_q == ST_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // [R21]
   property p_foreign;
      @(posedge clock) disable iff (rst)
      (state_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && !addr_hit && !start_ev && !stop_ev)
         |=> !sda_oe_q && state_q == ST_IDLE;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address answered"); // [R21]
   property p_wr_inc;
      @(posedge clock) disable iff (rst) (wr_ev && idx_q != IDX_LAST) |=> idx_q == $past(idx_q) + 7'h01;
   endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("index not advanced after write"); // [R3]
   property p_wrap;
      @(posedge clock) disable iff (rst) (wr_ev && idx_q == IDX_LAST) |=> idx_q == IDX_WRAP;
   endproperty
   a_wrap: assert property (p_wrap) else $error("index did not wrap"); // [R4]
   property p_page;
      @(posedge clock) disable iff (rst) (wr_ev && idx_q == REG_PAGE) |=> page_q == $past(shift_q);
   endproperty
   a_page: assert property (p_page) else $error("page select not taken"); // [R10]
   property p_book_guard;
      @(posedge clock) disable iff (rst) (wr_ev && page_q != PAGE_ZERO) |=> $stable(book_q);
   endproperty
   a_book_guard: assert property (p_book_guard) else $error("book changed off page zero"); // [R11]
   property p_rd_inc;
      @(posedge clock) disable iff (rst)
      (state_q == ST_ACK && rw_q && scl_fall && !start_ev && !stop_ev)
         |=> state_q == ST_TX && idx_q == next_idx($past(idx_q));
   endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("index not advanced after read"); // [R8]
   property p_nack;
      @(posedge clock) disable iff (rst)
      (state_q == ST_MACK && scl_rise && pins_s.sda && !start_ev && !stop_ev)
         |=> !sda_oe_q [*2];
   endproperty
   a_nack: assert property (p_nack) else $error("data driven after master nack"); // [R9]
   property p_swap_set;
      @(posedge clock) disable iff (rst) swap_go |=> swap_busy_q && (req_tgl_q != $past(req_tgl_q));
   endproperty
   a_swap_set: assert property (p_swap_set) else $error("swap flag not raised"); // [R17]
   property p_swap_hold;
      @(posedge clock) disable iff (rst) (swap_busy_q && done_s == seen_done_q) |=> swap_busy_q;
   endproperty
   a_swap_hold: assert property (p_swap_hold) else $error("swap flag dropped early"); // [R14]

endmodule : icp_port
`default_nettype wire

// file: icp_swap.sv
// Swap engine on the audio sample clock: copies the host coefficient
// buffer into processing memory in one sample period.
// Assumes the host buffer is held still while a request is pending.
`timescale 1ns/100ps
`default_nettype none
module icp_swap (
   input  wire logic           audio_clk,
   input  wire logic           rst,
   input  wire logic           req_tgl,
   input  wire icp_pkg::icp_coef_t host_mem,
   output var  logic           done_tgl_q,
   output var  icp_pkg::icp_coef_t proc_mem_q
);
   import icp_pkg::*;

   logic      req_s;
   logic      seen_q;
   logic      seen_d;
   logic      done_tgl_d;
   icp_coef_t proc_mem_d;
   logic      go;

   // Request toggle into the audio domain
   icp_sync #(.W(1)) u_req_sync (
      .clock (audio_clk),
      .rst   (rst),
      .d     (req_tgl),
      .q     (req_s)
   );

   // Whole buffer moves on one sample edge, and done toggles back on that same edge
   always_comb begin
      go         = req_s ^ seen_q;
      seen_d     = req_s;
      proc_mem_d = go ? host_mem : proc_mem_q;   // [R13]
      done_tgl_d = done_tgl_q ^ go;              // [R14]
   end

   // Registers
   always_ff @(posedge audio_clk or posedge rst) begin
      if (rst) begin
         seen_q     <= 1'b0;
         done_tgl_q <= 1'b0;
         proc_mem_q <= '0;
      end else begin
         seen_q     <= seen_d;
         done_tgl_q <= done_tgl_d;
         proc_mem_q <= proc_mem_d;
      end
   end

   // All coefficients change together on the request edge
   property p_copy;
      @(posedge audio_clk) disable iff (rst)
      go |=> (proc_mem_q == $past(host_mem)) && (done_tgl_q != $past(done_tgl_q));
   endproperty
   a_copy: assert property (p_copy) else $error("swap copy not done in one sample"); // [R13]

endmodule : icp_swap
`default_nettype wire

// file: icp_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
// Assumes inputs are levels held for several destination clocks.
`timescale 1ns/100ps
`default_nettype none
module icp_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   import icp_pkg::*;

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // Shift one stage per edge
   always_comb begin
      meta_d = d;
      q_d    = meta_q;
   end

   // Registers, cleared by reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= meta_d;
         q      <= q_d;
      end
   end

endmodule : icp_sync
`default_nettype wire

// file: tb_i2c_paged_control_port.sv
// Self-checking bench for the paged two-wire control port.
// Assumes icp_pkg, icp_port and icp_bus_master are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_paged_control_port;
   import icp_pkg::*;

   // ==========================================================
   // Signals and constants
   localparam int         OFF = int'({8'h1B, 7'h7E}) - int'(COEF_LIN_LO);
   logic       clock;
   logic       rst;
   logic       audio_clk;
   logic       scl;
   logic       sda_drv;
   logic       sda_w;
   logic       sda_o_q;
   logic       sda_oe_q;
   logic [7:0] page_q;
   logic [7:0] book_q;
   logic       swap_busy_q;
   icp_coef_t  proc_mem_q;
   logic       ack;
   logic       adr_hi;
   logic       adr_lo;
   logic [6:0] slv;
   logic       busy_prev;
   logic       busy_seen;
   int         n_fail;
   int         total_checks;

   // Open-drain line with pull-up
   assign sda_w = (sda_drv === 1'b0 || sda_oe_q === 1'b1) ? 1'b0 : 1'b1;

   icp_port DUT (.clock(clock), .rst(rst), .audio_clk(audio_clk), .scl_i(scl), .sda_i(sda_w),
      .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q), .address_select_high(adr_hi), .address_select_low(adr_lo),
      .page_q(page_q), .book_q(book_q), .swap_busy_q(swap_busy_q), .proc_mem_q(proc_mem_q));

   icp_bus_master #(.Q(8)) m (.clock(clock), .sda_line(sda_w), .scl(scl), .sda_drv(sda_drv));

   // ==========================================================
   // Clocks, unrelated phases
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      audio_clk = 1'b0;
      #3;
      forever #16 audio_clk = ~audio_clk;
   end

   // Swap flag monitor, memory must be copied when flag drops
   always @(posedge clock) begin
      busy_prev <= swap_busy_q;
      if (swap_busy_q === 1'b1) busy_seen <= 1'b1;
   end
   always @(negedge clock) begin
      if (busy_prev === 1'b1 && swap_busy_q === 1'b0) chk("mem_at_done", 8'hA5, proc_mem_q[OFF]);
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk

   task automatic complete_run();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic wr(input logic [6:0] r, input logic [7:0] b[$]);
      m.start();
      m.wbyte({slv, 1'b0}, ack);
      chk("ack_addr", 8'h01, 8'(ack));
      m.wbyte({1'b0, r}, ack);
      foreach (b[i]) begin
         m.wbyte(b[i], ack);
         chk("ack_data", 8'h01, 8'(ack));
      end
      m.stop();
   endtask : wr

   task automatic rd(input logic [6:0] r, input logic [7:0] e[$]);
      logic [7:0] d;
      m.start();
      m.wbyte({slv, 1'b0}, ack);
      m.wbyte({1'b0, r}, ack);
      m.start();
      m.wbyte({slv, 1'b1}, ack);
      chk("ack_read", 8'h01, 8'(ack));
      foreach (e[i]) begin
         m.rbyte(i == e.size() - 1, d);
         chk("rd_byte", e[i], d);
      end
      chk("oe_after_nack", 8'h00, 8'(sda_oe_q));
      m.stop();
   endtask : rd

   // ==========================================================
   // Main sequence
   initial begin
      n_fail = 0;
      total_checks = 0;
      busy_seen = 1'b0;
      adr_hi = 1'b1;
      adr_lo = 1'b0;
      slv = {ADDR_FIXED, 2'b10};
      rst = 1'b1;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      repeat (10) @(negedge clock);
      chk("page_rst", 8'h00, page_q);
      chk("book_rst", 8'h00, book_q);
      chk("busy_rst", 8'h00, 8'(swap_busy_q));
      // Foreign address must go unanswered
      m.start();
      m.wbyte({ADDR_FIXED, 2'b01, 1'b0}, ack);
      m.stop();
      chk("ack_other", 8'h00, 8'(ack));
      // Book change from page zero, then page change
      wr(REG_PAGE, '{8'h00});
      wr(REG_BOOK, '{8'h8C});
      chk("book", 8'h8C, book_q);
      wr(REG_PAGE, '{8'h1B});
      chk("page", 8'h1B, page_q);
      // Burst over the top of the page wraps onto the page register
      wr(7'h7E, '{8'hA5, 8'h3C, 8'h1C});
      chk("page_wrap", 8'h1C, page_q);
      wr(REG_PAGE, '{8'h1B});
      rd(7'h7E, '{8'hA5, 8'h3C, 8'h1B});
      chk("mem_pre_swap", 8'h00, proc_mem_q[OFF]);
      // Swap request
      wr(REG_PAGE, '{SWAP_PAGE});
      wr(SWAP_REG, '{8'h00, 8'h00, 8'h00, 8'h01});
      for (int i = 0; i < 2000 && swap_busy_q !== 1'b0; i++) @(negedge clock);
      if (swap_busy_q !== 1'b0) begin
         n_fail++;
         complete_run();
      end
      chk("busy_seen", 8'h01, 8'(busy_seen));
      chk("mem_swapped", 8'hA5, proc_mem_q[OFF]);
      chk("mem_next", 8'h3C, proc_mem_q[OFF+1]);
      rd(SWAP_REG, '{8'h00, 8'h00, 8'h00, 8'h00});
      // Select pins moved: new address answers, old one is ignored
      adr_hi = 1'b0;
      adr_lo = 1'b1;
      slv = {ADDR_FIXED, 2'b01};
      repeat (8) @(negedge clock);
      m.start();
      m.wbyte({ADDR_FIXED, 2'b10, 1'b0}, ack);
      m.stop();
      chk("ack_old_addr", 8'h00, 8'(ack));
      wr(REG_PAGE, '{8'h05});
      chk("page_pins", 8'h05, page_q);
      complete_run();
   end
endmodule : tb_i2c_paged_control_port
`default_nettype wire
